// [inc/evm_defines.vh]
/*
  constants of the exception vector mapper: vector numbers, interrupt
  line assignments, priority widths and reset values.
  assumes inclusion by bare name from the core files.
*/
// Function
// RQ1 - bus fault on vector 5, enableable
// RQ2 - usage fault on vector 6, synchronous
// RQ3 - supervisor call on vector 11
// RQ4 - debug monitor vector 12, enabled, priority-gated
// RQ5 - pendable service vector 14, software only
// RQ6 - system tick vector 15 when enabled
// RQ7 - external interrupts from vector 16, asynchronous
// RQ8 - programmable priorities reset to zero
// RQ9 - interrupt n is bit n, vector n+16
// RQ10 - both watchdogs share line 18, vector 34
// RQ11 - priority 0 ranks below reset, nmi, hard fault
// RQ12 - equal priority: lower number wins
// RQ13 - eight levels, 31 peripheral interrupts
// RQ14 - unassigned lines tied inactive
// RQ15 - irq level-sampled, pending until accepted/cleared
`ifndef EVM_DEFINES_VH
`define EVM_DEFINES_VH
`define EVM_VEC_W        8
`define EVM_PRI_W        3
`define EVM_IRQ_N        56
`define EVM_PRI_RESET    3'h0
`define EVM_VEC_NONE     8'h00
`define EVM_VEC_RESET    8'h01
`define EVM_VEC_NMI      8'h02
`define EVM_VEC_HARD     8'h03
`define EVM_VEC_MEM      8'h04
`define EVM_VEC_BUS      8'h05
`define EVM_VEC_USAGE    8'h06
`define EVM_VEC_SVC      8'h0b
`define EVM_VEC_DBG      8'h0c
`define EVM_VEC_PSV      8'h0e
`define EVM_VEC_TICK     8'h0f
`define EVM_VEC_IRQ_BASE 8'h10
`define EVM_IRQ_WDOG     18
// mask of interrupt lines with a source; all others tied off
`define EVM_IRQ_USED     56'h00_d826_37ff_c1ff
// fixed levels: reset, nmi, hard fault ahead of programmable 0
`define EVM_RANK_RESET   5'h00
`define EVM_RANK_NMI     5'h01
`define EVM_RANK_HARD    5'h02
`define EVM_RANK_PROG0   5'h03
`define EVM_RANK_NONE    5'h1f
`endif

// [core/evm_pend_cell.v]
/*
  one pending flag for one request source, with software set, clear and priority.
  assumes request already synchronised to clk.
*/
`timescale 1ns/1ps
`include "evm_defines.vh"
module evm_pend_cell #(
  parameter PRI_W = `EVM_PRI_W
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             req,
  input  wire             sw_set,
  input  wire             clr,
  input  wire             pri_we,
  input  wire [PRI_W-1:0] pri_wdata,
  output reg              pend_q,
  output reg  [PRI_W-1:0] pri_q
);
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 1'b0;
      pri_q  <= `EVM_PRI_RESET; // RQ8
    end else begin
      // set beats clear so a fresh level is never lost
      if (req || sw_set)
        pend_q <= 1'b1; // RQ15
      else if (clr)
        pend_q <= 1'b0; // RQ15
      if (pri_we)
        pri_q <= pri_wdata;
    end
  end
endmodule // evm_pend_cell

// [core/evm_mapper.v]
/*
  exception vector mapper: pends system exceptions and peripheral
  lines, picks the most urgent, presents its vector to the core.
  assumes core pulses vec_ack for the vector it takes, and that
  configuration inputs come from core-side logic on clk.
*/
`timescale 1ns/1ps
`include "evm_defines.vh"
module evm_mapper #(
  parameter IRQ_N = `EVM_IRQ_N,
  parameter PRI_W = `EVM_PRI_W
) (
  input  wire                   clk,
  input  wire                   nrst,
  input  wire                   nmi_req,
  input  wire                   hard_fault_req,
  input  wire                   mem_fault_req,
  input  wire                   bus_fault_req,
  input  wire                   bus_fault_en,
  input  wire                   usage_fault_req,
  input  wire                   supervisor_call_instr,
  input  wire                   debug_mon_req,
  input  wire                   debug_mon_en,
  input  wire                   pend_sv_sw_set,
  input  wire                   tick_zero,
  input  wire                   tick_int_en,
  input  wire [4:0]             gpio_irq,
  input  wire [2:0]             uart_irq,
  input  wire [1:0]             ssi_irq,
  input  wire [1:0]             i2c_irq,
  input  wire [3:0]             adc_seq_irq,
  input  wire                   wdog0_irq,
  input  wire                   wdog1_irq,
  input  wire [5:0]             timer_irq,
  input  wire [1:0]             comp_irq,
  input  wire                   sysctl_irq,
  input  wire                   flash_irq,
  input  wire                   hib_irq,
  input  wire                   usb_irq,
  input  wire                   dma_sw_irq,
  input  wire                   dma_err_irq,
  input  wire [IRQ_N-1:0]       irq_en,
  input  wire [IRQ_N-1:0]       irq_sw_pend,
  input  wire [IRQ_N-1:0]       irq_sw_clr,
  input  wire                   pri_we,
  input  wire [7:0]             pri_sel,
  input  wire [PRI_W-1:0]       pri_wdata,
  input  wire [4:0]             active_rank,
  input  wire                   vec_ack,
  output reg                    vec_valid_q,
  output reg  [`EVM_VEC_W-1:0]  vec_num_q,
  output reg                    vec_async_q,
  output reg  [4:0]             vec_rank_q
);
  // async pins pass two flops before use
  reg [IRQ_N-1:0] raw;
  reg [IRQ_N-1:0] sync1_q;
  reg [IRQ_N-1:0] sync2_q;
  reg             nmi1_q;
  reg             nmi2_q;

  always @* begin
    raw        = {IRQ_N{1'b0}}; // RQ14
    raw[4:0]   = gpio_irq;
    raw[5]     = uart_irq[0];
    raw[6]     = uart_irq[1];
    raw[7]     = ssi_irq[0];
    raw[8]     = i2c_irq[0];
    raw[17:14] = adc_seq_irq;
    raw[`EVM_IRQ_WDOG] = wdog0_irq | wdog1_irq; // RQ10
    raw[24:19] = timer_irq;
    raw[26:25] = comp_irq;
    raw[28]    = sysctl_irq;
    raw[29]    = flash_irq;
    raw[33]    = uart_irq[2];
    raw[34]    = ssi_irq[1];
    raw[37]    = i2c_irq[1];
    raw[43]    = hib_irq;
    raw[44]    = usb_irq;
    raw[46]    = dma_sw_irq;
    raw[47]    = dma_err_irq;
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= {IRQ_N{1'b0}};
      sync2_q <= {IRQ_N{1'b0}};
      nmi1_q  <= 1'b0;
      nmi2_q  <= 1'b0;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      nmi1_q  <= nmi_req;
      nmi2_q  <= nmi1_q;
    end
  end

  // system handler slots: 0 mem, 1 bus, 2 usage, 3 svc, 4 dbg, 5 psv, 6 tick
  localparam SYS_N = 7;
  wire [SYS_N-1:0] sys_req;
  wire [SYS_N-1:0] sys_pend;
  wire [SYS_N*PRI_W-1:0] sys_pri;
  wire [IRQ_N-1:0] irq_pend;
  wire [IRQ_N*PRI_W-1:0] irq_pri;
  wire [IRQ_N-1:0] used_mask = `EVM_IRQ_USED;

  // taken-vector decode drives the clears
  wire take = vec_valid_q & vec_ack;

  assign sys_req[0] = mem_fault_req;
  assign sys_req[1] = bus_fault_req & bus_fault_en; // RQ1
  assign sys_req[2] = usage_fault_req; // RQ2
  assign sys_req[3] = supervisor_call_instr; // RQ3
  assign sys_req[4] = debug_mon_req & debug_mon_en; // RQ4
  assign sys_req[5] = 1'b0; // RQ5
  assign sys_req[6] = tick_zero & tick_int_en; // RQ6

  genvar g;
  generate
    for (g = 0; g < SYS_N; g = g + 1) begin : g_sys
      wire [`EVM_VEC_W-1:0] vn = (g == 0) ? `EVM_VEC_MEM  : (g == 1) ? `EVM_VEC_BUS :
                                 (g == 2) ? `EVM_VEC_USAGE : (g == 3) ? `EVM_VEC_SVC :
                                 (g == 4) ? `EVM_VEC_DBG  : (g == 5) ? `EVM_VEC_PSV : `EVM_VEC_TICK;
      evm_pend_cell #(.PRI_W(PRI_W)) u_cell (
        .clk       (clk),
        .nrst      (nrst),
        .req       (sys_req[g]),
        .sw_set    ((g == 5) ? pend_sv_sw_set : 1'b0), // RQ5
        .clr       (take && vec_num_q == vn),
        .pri_we    (pri_we && pri_sel == vn),
        .pri_wdata (pri_wdata),
        .pend_q    (sys_pend[g]),
        .pri_q     (sys_pri[g*PRI_W +: PRI_W])
      );
    end
    for (g = 0; g < IRQ_N; g = g + 1) begin : g_irq
      evm_pend_cell #(.PRI_W(PRI_W)) u_cell (
        .clk       (clk),
        .nrst      (nrst),
        .req       (sync2_q[g] & used_mask[g]), // RQ14
        .sw_set    (irq_sw_pend[g] & used_mask[g]),
        .clr       (irq_sw_clr[g] || (take && vec_num_q == `EVM_VEC_IRQ_BASE + g)), // RQ9
        .pri_we    (pri_we && pri_sel == `EVM_VEC_IRQ_BASE + g),
        .pri_wdata (pri_wdata),
        .pend_q    (irq_pend[g]),
        .pri_q     (irq_pri[g*PRI_W +: PRI_W])
      );
    end
  endgenerate

  // selection: strict less-than keeps the lower number on ties
  reg [4:0]            best_rank;
  reg [`EVM_VEC_W-1:0] best_vec;
  reg                  best_async;
  reg [4:0]            r;
  integer              i;

  always @* begin
    best_rank  = `EVM_RANK_NONE;
    best_vec   = `EVM_VEC_NONE;
    best_async = 1'b0;
    r          = `EVM_RANK_NONE;
    if (nmi2_q) begin
      best_rank  = `EVM_RANK_NMI; // RQ11
      best_vec   = `EVM_VEC_NMI;
      best_async = 1'b1;
    end else if (hard_fault_req) begin
      best_rank  = `EVM_RANK_HARD; // RQ11
      best_vec   = `EVM_VEC_HARD;
    end else begin
      for (i = 0; i < SYS_N; i = i + 1) begin
        r = `EVM_RANK_PROG0 + {2'b00, sys_pri[i*PRI_W +: PRI_W]}; // RQ11
        if (sys_pend[i] && r < best_rank && !(i == 4 && r >= active_rank)) begin // RQ4
          best_rank  = r;
          best_vec   = (i == 0) ? `EVM_VEC_MEM : (i == 1) ? `EVM_VEC_BUS :
                       (i == 2) ? `EVM_VEC_USAGE : (i == 3) ? `EVM_VEC_SVC :
                       (i == 4) ? `EVM_VEC_DBG : (i == 5) ? `EVM_VEC_PSV : `EVM_VEC_TICK;
          best_async = (i >= 5) || (i == 1); // RQ1
        end
      end
      for (i = 0; i < IRQ_N; i = i + 1) begin
        r = `EVM_RANK_PROG0 + {2'b00, irq_pri[i*PRI_W +: PRI_W]};
        if (irq_pend[i] && irq_en[i] && r < best_rank) begin // RQ12
          best_rank  = r;
          best_vec   = `EVM_VEC_IRQ_BASE + i[`EVM_VEC_W-1:0]; // RQ7
          best_async = 1'b1; // RQ7
        end
      end
    end
  end

  // only exceptions beating the current activation are offered
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vec_valid_q <= 1'b0;
      vec_num_q   <= `EVM_VEC_NONE;
      vec_async_q <= 1'b0;
      vec_rank_q  <= `EVM_RANK_NONE;
    end else begin
      vec_valid_q <= (best_rank < active_rank) && !take;
      vec_num_q   <= best_vec;
      vec_async_q <= best_async;
      vec_rank_q  <= best_rank;
    end
  end
endmodule // evm_mapper

// [tb/evm_checker.sv]
/* output assertions for evm_mapper.
   assumes binding to evm_mapper, one clock domain. */
`timescale 1ns/1ps
module evm_checker (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       usage_fault_req,
  input wire logic [4:0] active_rank,
  input wire logic       vec_ack,
  input wire logic       vec_valid_q,
  input wire logic [7:0] vec_num_q,
  input wire logic       vec_async_q,
  input wire logic [4:0] vec_rank_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_rsv; vec_valid_q |-> !(vec_num_q inside {8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d}); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved vector");
  property p_ext; vec_valid_q && vec_num_q >= 8'h10 |-> vec_async_q && vec_rank_q >= 5'h03; endproperty
  a_ext: assert property (p_ext) else $error("bad irq class");
  property p_nmi; vec_valid_q && vec_num_q == 8'h02 |-> vec_rank_q == 5'h01; endproperty
  a_nmi: assert property (p_nmi) else $error("bad nmi rank");
  property p_drop; vec_valid_q && vec_ack |=> !vec_valid_q; endproperty
  a_drop: assert property (p_drop) else $error("valid after ack");
  property p_asy; vec_valid_q && vec_num_q inside {8'h0e, 8'h0f} |-> vec_async_q; endproperty
  a_asy: assert property (p_asy) else $error("not async");
  property p_syn; vec_valid_q && vec_num_q inside {8'h06, 8'h0b, 8'h0c} |-> !vec_async_q; endproperty
  a_syn: assert property (p_syn) else $error("not sync");
  // two cycles nominal, one spare for a drop on ack
  property p_lat; $rose(usage_fault_req) |-> ##[1:3] vec_valid_q; endproperty
  a_lat: assert property (p_lat) else $error("slow offer");
  property p_dbg; vec_valid_q && vec_num_q == 8'h0c && $stable(active_rank) |-> vec_rank_q < active_rank; endproperty
  a_dbg: assert property (p_dbg) else $error("monitor too low");
endmodule // evm_checker
bind evm_mapper evm_checker evm_checker_i (.*);

// [tb/evm_core_model.sv]
/* core side: takes each offered vector, promptly or after a wait.
   assumes vec_ack sampled by the mapper on clk. */
`timescale 1ns/1ps
module evm_core_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        slow,
  input  wire logic        vec_valid_q,
  input  wire logic [7:0]  vec_num_q,
  input  wire logic [4:0]  vec_rank_q,
  output logic             vec_ack,
  output logic             took,
  output logic [12:0]      taken
);
  logic [1:0] wait_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vec_ack <= 1'b0;
      took <= 1'b0;
      taken <= 13'h0;
      wait_q <= 2'h0;
    end else if (vec_ack) begin
      // record what the mapper holds at the taking edge
      vec_ack <= 1'b0;
      took <= 1'b1;
      taken <= {vec_rank_q, vec_num_q};
    end else begin
      took <= 1'b0;
      if (vec_valid_q && (!slow || wait_q == 2'h3)) begin
        vec_ack <= 1'b1;
        wait_q <= 2'h0;
      end else if (vec_valid_q) begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule // evm_core_model

// [tb/exception_vector_mapper_tb.sv]
/* bench: pulses sources, predicts vector and rank of each take.
   assumes 40 MHz clk and evm_core_model as the core. */
`timescale 1ns/1ps
module exception_vector_mapper_tb;
  logic        clk, nrst, slow, took, vec_ack, pri_we, nmi_req, vec_valid_q, vec_async_q;
  logic        bus_fault_en, debug_mon_en, tick_int_en, hard_fault_req;
  logic [55:0] irq_sw_clr;
  logic [5:0]  sys;
  logic [31:0] src;
  logic [55:0] irq_en, irq_sw_pend;
  logic [7:0]  pri_sel, vec_num_q;
  logic [2:0]  pri_wdata;
  logic [4:0]  active_rank, vec_rank_q;
  logic [12:0] taken;
  logic [12:0] q[$];
  int err_total, checks, cyc, i, j, a, b, t;
  int pri[256];
  int ln[32] = '{0,1,2,3,4,5,6,33,7,34,8,37,14,15,16,17,18,18,19,20,21,22,23,24,25,26,28,29,43,44,46,47};
  int sv[6] = '{5, 6, 11, 12, 14, 15};
  evm_mapper evm_mapper_i (.clk(clk), .nrst(nrst), .nmi_req(nmi_req), .hard_fault_req(hard_fault_req),
    .mem_fault_req(1'b0),
    .bus_fault_req(sys[0]), .bus_fault_en(bus_fault_en), .usage_fault_req(sys[1]), .supervisor_call_instr(sys[2]),
    .debug_mon_req(sys[3]), .debug_mon_en(debug_mon_en), .pend_sv_sw_set(sys[4]), .tick_zero(sys[5]),
    .tick_int_en(tick_int_en), .gpio_irq(src[4:0]), .uart_irq(src[7:5]), .ssi_irq(src[9:8]), .i2c_irq(src[11:10]),
    .adc_seq_irq(src[15:12]), .wdog0_irq(src[16]), .wdog1_irq(src[17]), .timer_irq(src[23:18]),
    .comp_irq(src[25:24]), .sysctl_irq(src[26]), .flash_irq(src[27]), .hib_irq(src[28]), .usb_irq(src[29]),
    .dma_sw_irq(src[30]), .dma_err_irq(src[31]), .irq_en(irq_en), .irq_sw_pend(irq_sw_pend), .irq_sw_clr(irq_sw_clr),
    .pri_we(pri_we), .pri_sel(pri_sel), .pri_wdata(pri_wdata), .active_rank(active_rank), .vec_ack(vec_ack),
    .vec_valid_q(vec_valid_q), .vec_num_q(vec_num_q), .vec_async_q(vec_async_q), .vec_rank_q(vec_rank_q));
  evm_core_model evm_core_model_i (.clk(clk), .nrst(nrst), .slow(slow), .vec_valid_q(vec_valid_q),
    .vec_num_q(vec_num_q), .vec_rank_q(vec_rank_q), .vec_ack(vec_ack), .took(took), .taken(taken));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (took) q.push_back(taken);
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      tally_and_finish;
    end
  end
  task automatic chk(logic [12:0] g, logic [12:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic take(int v);
    for (int n = 0; n < 40 && q.size() == 0; n++) @(posedge clk);
    chk(q.size() ? q.pop_front() : 13'h1fff, {5'(3 + pri[v]), 8'(v)});
  endtask
  task automatic none();
    repeat (15) @(posedge clk);
    chk(13'(q.size()), 13'h0);
  endtask
  task automatic pls(logic [31:0] m, logic [5:0] s);
    @(posedge clk) begin
      src <= m;
      sys <= s;
    end
    @(posedge clk) begin
      src <= 32'h0;
      sys <= 6'h0;
    end
  endtask
  task automatic pw(int v, int p);
    @(posedge clk) begin
      pri_we <= 1'b1;
      pri_sel <= 8'(v);
      pri_wdata <= 3'(p);
    end
    pri[v] = p;
    @(posedge clk) pri_we <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {nrst, slow, pri_we, nmi_req, sys, src, irq_sw_pend, pri_sel, pri_wdata, hard_fault_req, irq_sw_clr} = '0;
    {bus_fault_en, debug_mon_en, tick_int_en, active_rank, irq_en} = '1;
    foreach (pri[k]) pri[k] = 0;
    pri[2] = -2; // nmi ranks fixed at 1
    pri[3] = -1; // hard fault ranks fixed at 2
    void'($urandom(81));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int k = 0; k < 32; k++) begin
      slow <= 1'($urandom);
      pls(32'h1 << k, 6'h0);
      take(16 + ln[k]);
    end
    $display("lines done");
    for (int k = 0; k < 6; k++) begin
      i = $urandom % 32;
      j = (i + 1 + $urandom % 30) % 32;
      if (ln[i] == ln[j]) j = (j + 2) % 32;
      pw(16 + ln[i], $urandom % 8);
      pw(16 + ln[j], $urandom % 8);
      a = 16 + ln[i];
      b = 16 + ln[j];
      if (pri[b] < pri[a] || (pri[b] == pri[a] && b < a)) begin
        t = a;
        a = b;
        b = t;
      end
      pls((32'h1 << i) | (32'h1 << j), 6'h0);
      take(a);
      take(b);
    end
    $display("priority done");
    for (int k = 0; k < 6; k++) begin
      pls(32'h0, 6'h1 << k);
      take(sv[k]);
    end
    @(posedge clk) irq_sw_pend <= 56'h200;
    @(posedge clk) irq_sw_pend <= 56'h0;
    none();
    @(posedge clk) irq_en <= ~56'h1;
    pls(32'h1, 6'h0);
    none();
    @(posedge clk) irq_en <= '1;
    take(16);
    @(posedge clk) irq_en <= ~56'h1;
    pls(32'h1, 6'h0);
    repeat (6) @(posedge clk);
    @(posedge clk) irq_sw_clr <= 56'h1;
    @(posedge clk) begin
      irq_sw_clr <= 56'h0;
      irq_en <= '1;
    end
    none();
    $display("system done");
    // nmi level is not latched, so repeat takes are legal
    slow <= 1'b0;
    @(posedge clk) nmi_req <= 1'b1;
    pls(32'h1, 6'h0);
    take(2);
    nmi_req <= 1'b0;
    repeat (12) @(posedge clk);
    chk(q.size() ? q[$] : 13'h1fff, {5'(3 + pri[16]), 8'h10});
    q.delete();
    @(posedge clk) begin
      bus_fault_en <= 1'b0;
      tick_int_en <= 1'b0;
    end
    pls(32'h0, 6'h21);
    none();
    @(posedge clk) active_rank <= 5'h03;
    pls(32'h0, 6'h08);
    none();
    @(posedge clk) hard_fault_req <= 1'b1;
    take(3);
    hard_fault_req <= 1'b0;
    repeat (4) @(posedge clk);
    q.delete();
    none();
    $display("gating done");
    tally_and_finish;
  end
endmodule // exception_vector_mapper_tb
